// *** bench/adma_mem_model.sv ***
// Purpose: memory and slot arbiter facing adma_top
// Assumes: one requester per cycle, data read while the request stands
// Notes: idle data bus toggles so a stale word never matches
`timescale 1ns/100ps
module adma_mem_model (
    // Clock and reset
    input wire clock_i,
    input wire nrst_i,
    // Pace, high spaces slots widely
    input wire slow_i,
    // Design side
    input wire [3:0] mem_req_i,
    input wire [71:0] mem_addr_i,
    output logic [3:0] slot_o = 4'h0,
    output logic [15:0] mem_data_o
);
    logic [3:0] cnt = 4'h0;
    logic [1:0] ch = 2'h0;
    logic [15:0] last = 16'h0000;
    logic [17:0] a;
    function automatic logic [15:0] word(input logic [17:0] p);
        word = {p[7:0] ^ 8'ha5, ~p[7:0]};
    endfunction
    // Round-robin slots, one channel at a time
    always @(posedge clock_i) begin
        last <= mem_data_o;
        slot_o <= 4'h0;
        cnt <= cnt + 4'h1;
        if (cnt >= (slow_i ? 4'h6 : 4'h1)) begin
            cnt <= 4'h0;
            ch <= ch + 2'h1;
            slot_o <= 4'h1 << ch;
        end
    end
    always @* begin
        a = mem_addr_i[17:0];
        if (mem_req_i[1]) a = mem_addr_i[35:18];
        if (mem_req_i[2]) a = mem_addr_i[53:36];
        if (mem_req_i[3]) a = mem_addr_i[71:54];
    end
    assign mem_data_o = (mem_req_i != 4'h0) ? word(a) : ~last;
endmodule

// *** bench/adma_top_chk.sv ***
// Purpose: port assertions for adma_top
// Assumes: shadows of control and attach track register writes
// Notes: a few cycles of pipeline slack are allowed at enables
`timescale 1ns/100ps
module adma_top_chk (
    // Clock and reset
    input wire clock_i,
    input wire nrst_i,
    // Register port
    input wire [5:0] reg_addr_i,
    input wire [15:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    input wire [15:0] reg_rdata_o,
    // Slots and memory
    input wire [3:0] slot_i,
    input wire [15:0] mem_data_i,
    input wire [3:0] mem_req_o,
    input wire [71:0] mem_addr_o,
    // Events and output
    input wire [3:0] irq_o,
    input wire [31:0] sample_o,
    input wire [27:0] volume_o
);
    reg [15:0] ctl;
    reg [7:0] att;
    reg [3:0] s1, s2, s3;
    wire [3:0] run = ctl[9] ? ctl[3:0] : 4'h0;
    wire [3:0] sil = att[3:0] | att[7:4];
    // Silence judged only once attach has stood three cycles
    wire [3:0] sd = sil & s3;
    wire [31:0] msk = {{8{sd[3]}}, {8{sd[2]}}, {8{sd[1]}}, {8{sd[0]}}};
    wire vw0 = reg_wr_i && reg_addr_i == 6'h13;
    wire vw1 = reg_wr_i && reg_addr_i == 6'h17;
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            ctl <= 16'h0000;
            att <= 8'h00;
            s1 <= 4'h0;
            s2 <= 4'h0;
            s3 <= 4'h0;
        end else begin
            if (reg_wr_i && reg_addr_i == 6'h00) begin
                ctl <= reg_wdata_i[15] ? (ctl | reg_wdata_i)
                    : (ctl & ~reg_wdata_i);
            end
            if (reg_wr_i && reg_addr_i == 6'h01) begin
                att <= reg_wdata_i[7:0];
            end
            s1 <= sil;
            s2 <= s1;
            s3 <= s2;
        end
    end
    // ---
    // Properties
    // ---
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (!nrst_i);
    property p_irq_run;
        irq_o != 4'h0 |-> (irq_o & ~($past(run) | $past(run, 2)
            | $past(run, 3))) == 4'h0;
    endproperty
    a_irq_run: assert property (p_irq_run) else $error("irq idle");
    property p_irq_start;
        (run & ~$past(run)) != 4'h0 |-> ##[1:4] irq_o != 4'h0;
    endproperty
    a_irq_start: assert property (p_irq_start) else $error("no irq");
    property p_irq_pulse;
        irq_o != 4'h0 |=> (irq_o & $past(irq_o)) == 4'h0;
    endproperty
    a_irq_pulse: assert property (p_irq_pulse) else $error("irq long");
    property p_req_slot;
        mem_req_o != 4'h0 |-> (mem_req_o & ~($past(slot_i, 2)
            | $past(slot_i, 3) | $past(slot_i, 4) | $past(slot_i, 5)))
            == 4'h0;
    endproperty
    a_req_slot: assert property (p_req_slot) else $error("no slot");
    property p_req_once;
        $rose(mem_req_o[0]) |=> !mem_req_o[0] [*3];
    endproperty
    a_req_once: assert property (p_req_once) else $error("req run");
    property p_req_run;
        mem_req_o != 4'h0 |-> (mem_req_o & ~(run | $past(run, 2)
            | $past(run, 4) | $past(run, 6))) == 4'h0;
    endproperty
    a_req_run: assert property (p_req_run) else $error("req off");
    property p_silent;
        (sample_o & msk) == 32'h0;
    endproperty
    a_silent: assert property (p_silent) else $error("not silent");
    property p_vol1_src;
        $changed(volume_o[13:7]) |-> att[0] || $past(att[0])
            || $past(vw1) || $past(vw1, 2);
    endproperty
    a_vol1_src: assert property (p_vol1_src) else $error("vol1");
    property p_vol0_src;
        $changed(volume_o[6:0]) |-> $past(vw0) || $past(vw0, 2);
    endproperty
    a_vol0_src: assert property (p_vol0_src) else $error("vol0");
endmodule
bind adma_top adma_top_chk i_adma_top_chk (.clock_i, .nrst_i, .reg_addr_i,
    .reg_wdata_i, .reg_wr_i, .reg_rd_i, .reg_rdata_o, .slot_i, .mem_data_i,
    .mem_req_o, .mem_addr_o, .irq_o, .sample_o, .volume_o);

// *** bench/adma_top_test.sv ***
// Purpose: self-checking bench for adma_top
// Assumes: memory word at p is {p[7:0]^a5, ~p[7:0]}
// Notes: location 0x0700 gives pointers 0x1c00 and 0x1c01
`timescale 1ns/100ps
module adma_top_test;
    logic clock_i = 1'b0;
    logic nrst_i = 1'b0;
    logic [5:0] reg_addr_i = 6'h00;
    logic [15:0] reg_wdata_i = 16'h0000;
    logic reg_wr_i = 1'b0;
    logic reg_rd_i = 1'b0;
    logic slow_i = 1'b0;
    wire [15:0] reg_rdata_o, mem_data_i;
    wire [3:0] slot_i, mem_req_o, irq_o;
    wire [71:0] mem_addr_o;
    wire [31:0] sample_o;
    wire [27:0] volume_o;
    int fail_count = 0;
    int compares = 0;
    int n;
    logic [15:0] v;
    logic [3:0] acc;
    always #4 clock_i = ~clock_i;
    adma_top i_adma_top (.clock_i, .nrst_i, .reg_addr_i, .reg_wdata_i,
        .reg_wr_i, .reg_rd_i, .reg_rdata_o, .slot_i, .mem_data_i,
        .mem_req_o, .mem_addr_o, .irq_o, .sample_o, .volume_o);
    adma_mem_model i_adma_mem_model (.clock_i, .nrst_i, .slow_i,
        .mem_req_i(mem_req_o), .mem_addr_i(mem_addr_o), .slot_o(slot_i),
        .mem_data_o(mem_data_i));
    // ---
    // Tasks
    // ---
    task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        compares++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s exp %h got %h", nm, e, g);
        end
    endtask
    task wr(input logic [5:0] a, input logic [15:0] d);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_wdata_i <= d;
        reg_wr_i <= 1'b1;
        @(posedge clock_i);
        reg_wr_i <= 1'b0;
    endtask
    task rd(input logic [5:0] a, output logic [15:0] d);
        @(posedge clock_i);
        reg_addr_i <= a;
        reg_rd_i <= 1'b1;
        @(posedge clock_i);
        reg_rd_i <= 1'b0;
        #1 d = reg_rdata_o;
    endtask
    task wait_ev(input bit req, input int c, input string nm);
        for (n = 0; n < 2000; n++) begin
            @(posedge clock_i) #1;
            if ((req ? mem_req_o[c] : irq_o[c]) === 1'b1) return;
        end
        chk(nm, 1, 0);
    endtask
    task poll(input logic [5:0] a, input logic [15:0] e);
        for (n = 0; n < 300; n++) begin
            rd(a, v);
            if (v === e) break;
        end
        chk("period reg", e, v);
    endtask
    task vwait(input logic [6:0] e);
        for (n = 0; n < 2000 && volume_o[13:7] !== e; n++)
            @(posedge clock_i) #1;
        chk("ch1 volume_o", e, volume_o[13:7]);
    endtask
    // Park ch0 long enough to restart its block, then reattach
    task remod(input logic [15:0] a);
        wr(6'h00, 16'h0001);
        repeat (300) @(posedge clock_i);
        wr(6'h16, 16'h0020);
        wr(6'h17, 16'h0000);
        wr(6'h01, a);
        wr(6'h00, 16'h8001);
    endtask
    function automatic logic [15:0] cfg(input int c, input int f);
        case (f)
            0: cfg = 16'((c + 1) << 8);
            1: cfg = 16'h0002;
            2: cfg = 16'h0020;
            default: cfg = 16'(16'h0011 + c);
        endcase
    endfunction
    task results;
        $display("compares %0d fail_count %0d", compares, fail_count);
        if (fail_count == 0 && compares > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    initial begin
        #200000;
        fail_count++;
        results;
    end
    // ---
    // Tests
    // ---
    initial begin
        repeat (10) @(posedge clock_i);
        nrst_i <= 1'b1;
        @(posedge clock_i) #1;
        chk("sample_o", 32'h0, sample_o);
        for (int c = 0; c < 4; c++) begin
            rd(6'(18 + 4 * c), v);
            chk("period reset", 16'h01bf, v);
        end
        wr(6'h3f, 16'hffff);
        rd(6'h3f, v);
        chk("unmapped", 16'h0000, v);
        for (int c = 0; c < 4; c++)
            for (int f = 0; f < 4; f++)
                wr(6'(16 + 4 * c + f), cfg(c, f));
        for (int c = 0; c < 4; c++)
            for (int f = 0; f < 4; f++) begin
                rd(6'(16 + 4 * c + f), v);
                chk("chan reg", cfg(c, f), v);
            end
        chk("volume_o", {7'h14, 7'h13, 7'h12, 7'h11}, volume_o);
        wr(6'h00, 16'h800f);
        acc = 4'h0;
        repeat (40) begin
            @(posedge clock_i) #1;
            acc |= irq_o | mem_req_o;
        end
        chk("dma without master", 4'h0, acc);
        wr(6'h00, 16'h8200);
        wait_ev(0, 0, "start irq");
        chk("irq_o", 4'hf, irq_o);
        wait_ev(1, 0, "first fetch");
        chk("ch0 addr", 18'h00400, mem_addr_o[17:0]);
        wr(6'h10, 16'h0700);
        wait_ev(1, 0, "second fetch");
        chk("ch0 addr", 18'h00401, mem_addr_o[17:0]);
        wait_ev(0, 0, "reload irq");
        wait_ev(1, 0, "reload fetch");
        chk("ch0 addr", 18'h01c00, mem_addr_o[17:0]);
        rd(6'h02, v);
        chk("irq status", 16'h000f, v);
        for (n = 0; n < 200 && sample_o[7:0] !== 8'ha5; n++)
            @(posedge clock_i) #1;
        chk("ch0 sample", 8'ha5, sample_o[7:0]);
        slow_i <= 1'b1;
        remod(16'h0001);
        vwait(7'h7f);
        vwait(7'h7e);
        chk("ch0 sample", 8'h00, sample_o[7:0]);
        rd(6'h16, v);
        chk("ch1 period", 16'h0020, v);
        wait_ev(0, 1, "ch1 irq");
        wait_ev(1, 1, "ch1 fetch");
        chk("ch1 addr", 18'h00800, mem_addr_o[35:18]);
        remod(16'h0010);
        poll(6'h16, 16'ha5ff);
        remod(16'h0011);
        poll(6'h16, 16'ha4fe);
        chk("ch1 volume_o", 7'h7f, volume_o[13:7]);
        wr(6'h01, 16'h0088);
        rd(6'h01, v);
        chk("attach reg", 16'h0088, v);
        repeat (100) @(posedge clock_i);
        #1 chk("ch3 sample", 8'h00, sample_o[31:24]);
        for (n = 0; n < 200 && sample_o[7:0] !== 8'ha4; n++)
            @(posedge clock_i) #1;
        chk("ch0 sample", 8'ha4, sample_o[7:0]);
        results;
    end
endmodule

// *** src/adma_channel.v ***
// Purpose: one audio DMA channel: back-up regs, fetch, period timer
// Assumes: memory returns word data in the cycle after fetch_o
// Notes: period/volume live here so modulation writes look like sw writes
`timescale 1ns/100ps
`include "adma_consts.vh"
module adma_channel (
    // Clock and reset
    input wire clock_i,
    input wire nrst_i,
    // Control
    input wire run_i,
    input wire slot_i,
    input wire [17:0] location_i,
    input wire [15:0] length_i,
    // Period and volume writes (software or modulator)
    input wire per_we_i,
    input wire [15:0] per_i,
    input wire vol_we_i,
    input wire [6:0] vol_i,
    // Memory side
    input wire [15:0] mem_data_i,
    output reg fetch_o,
    output reg [17:0] addr_o,
    // Status
    output reg block_start_o,
    output reg tick_o,
    output reg [15:0] word_o,
    output reg [15:0] period_o,
    output reg [6:0] volume_o
);
    reg [15:0] back_len;
    reg [15:0] per_cnt;
    reg loaded;
    reg pending;
    reg fetched;
    reg [1:0] idle_samples;

    // -----------------------------------------------------------
    // Period timer and sample word
    // -----------------------------------------------------------
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            period_o <= `ADMA_RST_PERIOD;
            volume_o <= `ADMA_RST_VOLUME;
            per_cnt <= 16'h0000;
            tick_o <= 1'b0;
            word_o <= 16'h0000;
            fetched <= 1'b0;
            pending <= 1'b0;
        end else begin
            tick_o <= 1'b0;
            if (per_we_i) begin
                period_o <= per_i;
            end
            if (vol_we_i) begin
                volume_o <= vol_i;
            end
            fetched <= fetch_o;
            if (fetched) begin
                pending <= 1'b1;
            end
            if (per_cnt == 16'h0000) begin
                per_cnt <= period_o;
                if (pending || fetched) begin
                    tick_o <= 1'b1;
                    word_o <= fetched ? mem_data_i : word_o;
                    pending <= 1'b0;
                end
            end else begin
                per_cnt <= per_cnt - 16'h0001;
            end
            if (fetched && per_cnt != 16'h0000) begin
                word_o <= mem_data_i;
            end
        end
    end

    // -----------------------------------------------------------
    // Back-up registers and fetch
    // -----------------------------------------------------------
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            back_len <= 16'h0000;
            addr_o <= 18'h00000;
            loaded <= 1'b0;
            block_start_o <= 1'b0;
            fetch_o <= 1'b0;
            idle_samples <= 2'h0;
        end else begin
            block_start_o <= 1'b0;
            fetch_o <= 1'b0;
            if (!run_i) begin
                // Short disable keeps position, longer one restarts
                if (tick_o || per_cnt == 16'h0000) begin
                    if (idle_samples != 2'h3) begin
                        idle_samples <= idle_samples + 2'h1;
                    end
                end
                if (idle_samples >= `ADMA_REENABLE_SAMPLES) begin
                    loaded <= 1'b0;
                end
            end else begin
                idle_samples <= 2'h0;
                if (!loaded) begin
                    addr_o <= location_i;
                    back_len <= length_i;
                    loaded <= 1'b1;
                    block_start_o <= 1'b1;
                end else if (fetch_o) begin
                    // Pointer moves only after the word left on it
                    if (back_len <= 16'h0001) begin
                        addr_o <= location_i;
                        back_len <= length_i;
                        block_start_o <= 1'b1;
                    end else begin
                        addr_o <= addr_o + 18'h00001;
                        back_len <= back_len - 16'h0001;
                    end
                end else if (slot_i && !pending && !fetched) begin
                    fetch_o <= 1'b1;
                end
            end
        end
    end
endmodule

// *** src/adma_consts.vh ***
// Purpose: constants for the four-channel audio DMA block
// Assumes: register index is the plain port address
// Notes: offsets of own choosing, see hand-over
`ifndef ADMA_CONSTS_VH
`define ADMA_CONSTS_VH
// Global registers
`define ADMA_ADDR_DMA_CONTROL 6'h00
`define ADMA_ADDR_ATTACH 6'h01
`define ADMA_ADDR_IRQ_STATUS 6'h02
// Per channel block: base 0x10 + 4*ch, words loc, len, per, vol
`define ADMA_ADDR_CH_BASE 6'h10
`define ADMA_CH_LOC 2'h0
`define ADMA_CH_LEN 2'h1
`define ADMA_CH_PER 2'h2
`define ADMA_CH_VOL 2'h3
// Field positions
`define ADMA_DMA_MASTER_BIT 9
`define ADMA_SETCLR_BIT 15
`define ADMA_VOL_ATTACH_LSB 0
`define ADMA_PER_ATTACH_LSB 4
`define ADMA_VOL_MSB 6
// Reset values
`define ADMA_RST_PERIOD 16'h01bf
`define ADMA_RST_VOLUME 7'h00
// Re-enable within this many samples may continue
`define ADMA_REENABLE_SAMPLES 2
`endif

// *** src/adma_top.v ***
// Purpose: four-channel audio DMA with attach modulation
// Assumes: one memory word per granted slot, data one cycle later
// Notes: sample output is the high byte of the held word; silenced channels output 0
`timescale 1ns/100ps
`include "adma_consts.vh"
module adma_top (
    // Clock and reset
    input wire clock_i,
    input wire nrst_i,
    // Register port
    input wire [5:0] reg_addr_i,
    input wire [15:0] reg_wdata_i,
    input wire reg_wr_i,
    input wire reg_rd_i,
    output reg [15:0] reg_rdata_o,
    // DMA slots and memory
    input wire [3:0] slot_i,
    input wire [15:0] mem_data_i,
    output reg [3:0] mem_req_o,
    output reg [71:0] mem_addr_o,
    // Channel events and output
    output reg [3:0] irq_o,
    output reg [31:0] sample_o,
    output reg [27:0] volume_o
);
    reg [15:0] dma_control;
    reg [7:0] audio_attach_control;
    reg [3:0] irq_status;
    reg [17:0] channel_location [0:3];
    reg [15:0] channel_length [0:3];
    reg [3:0] alt_period;
    reg [3:0] slot_m1;
    reg [3:0] slot_m2;

    wire [3:0] ch_fetch;
    wire [3:0] ch_start;
    wire [3:0] ch_tick;
    wire [71:0] ch_addr;
    wire [63:0] ch_word;
    wire [63:0] ch_period;
    wire [27:0] ch_volume;
    reg [3:0] mod_vol_we;
    reg [3:0] mod_per_we;
    reg [63:0] mod_word;
    reg [3:0] sw_per_we;
    reg [3:0] sw_vol_we;

    integer k;

    // Channel register write decode, used for several fields
    function ch_hit;
        input [5:0] addr;
        input [1:0] ch;
        input [1:0] field;
        begin
            ch_hit = (addr == (`ADMA_ADDR_CH_BASE | {2'h0, ch, field}));
        end
    endfunction

    // -----------------------------------------------------------
    // Slot strobes arrive from the arbiter pins
    // -----------------------------------------------------------
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            slot_m1 <= 4'h0;
            slot_m2 <= 4'h0;
        end else begin
            slot_m1 <= slot_i;
            slot_m2 <= slot_m1;
        end
    end

    // -----------------------------------------------------------
    // Software registers
    // -----------------------------------------------------------
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            dma_control <= 16'h0000;
            audio_attach_control <= 8'h00;
            for (k = 0; k < 4; k = k + 1) begin
                channel_location[k] <= 18'h00000;
                channel_length[k] <= 16'h0000;
            end
        end else if (reg_wr_i) begin
            if (reg_addr_i == `ADMA_ADDR_DMA_CONTROL) begin
                // Set/clear style write
                if (reg_wdata_i[`ADMA_SETCLR_BIT]) begin
                    dma_control <= dma_control | {1'b0, reg_wdata_i[14:0]};
                end else begin
                    dma_control <= dma_control
                                   & ~{1'b0, reg_wdata_i[14:0]};
                end
            end
            if (reg_addr_i == `ADMA_ADDR_ATTACH) begin
                audio_attach_control <= reg_wdata_i[7:0];
            end
            for (k = 0; k < 4; k = k + 1) begin
                // Only the live registers change; back-ups untouched
                if (ch_hit(reg_addr_i, k[1:0], `ADMA_CH_LOC)) begin
                    channel_location[k] <= {reg_wdata_i, 2'h0};
                end
                if (ch_hit(reg_addr_i, k[1:0], `ADMA_CH_LEN)) begin
                    channel_length[k] <= reg_wdata_i;
                end
            end
        end
    end

    always @* begin
        for (k = 0; k < 4; k = k + 1) begin
            sw_per_we[k] = reg_wr_i
                           && ch_hit(reg_addr_i, k[1:0], `ADMA_CH_PER);
            sw_vol_we[k] = reg_wr_i
                           && ch_hit(reg_addr_i, k[1:0], `ADMA_CH_VOL);
        end
    end

    // -----------------------------------------------------------
    // Block-start events, sticky; read of status clears, set wins
    // -----------------------------------------------------------
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            irq_status <= 4'h0;
            irq_o <= 4'h0;
        end else begin
            if (reg_rd_i && reg_addr_i == `ADMA_ADDR_IRQ_STATUS) begin
                irq_status <= ch_start;
            end else begin
                irq_status <= irq_status | ch_start;
            end
            irq_o <= ch_start;
        end
    end

    // -----------------------------------------------------------
    // Read port
    // -----------------------------------------------------------
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            reg_rdata_o <= 16'h0000;
        end else begin
            reg_rdata_o <= 16'h0000;
            if (reg_rd_i) begin
                case (reg_addr_i)
                    `ADMA_ADDR_DMA_CONTROL: reg_rdata_o <= dma_control;
                    `ADMA_ADDR_ATTACH: begin
                        reg_rdata_o <= {8'h00, audio_attach_control};
                    end
                    `ADMA_ADDR_IRQ_STATUS: begin
                        reg_rdata_o <= {12'h000, irq_status};
                    end
                    default: begin
                        for (k = 0; k < 4; k = k + 1) begin
                            if (ch_hit(reg_addr_i, k[1:0], `ADMA_CH_LOC))
                                reg_rdata_o <= channel_location[k][17:2];
                            if (ch_hit(reg_addr_i, k[1:0], `ADMA_CH_LEN))
                                reg_rdata_o <= channel_length[k];
                            if (ch_hit(reg_addr_i, k[1:0], `ADMA_CH_PER))
                                reg_rdata_o <= ch_period[k*16 +: 16];
                            if (ch_hit(reg_addr_i, k[1:0], `ADMA_CH_VOL))
                                reg_rdata_o <= {9'h000,
                                                ch_volume[k*7 +: 7]};
                        end
                    end
                endcase
            end
        end
    end

    // -----------------------------------------------------------
    // Modulation routing: channel n feeds channel n+1
    // -----------------------------------------------------------
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            alt_period <= 4'h0;
        end else begin
            for (k = 0; k < 4; k = k + 1) begin
                if (!(audio_attach_control[k]
                      && audio_attach_control[k+4])) begin
                    alt_period[k] <= 1'b0;
                end else if (ch_tick[k]) begin
                    alt_period[k] <= ~alt_period[k];
                end
            end
        end
    end

    always @* begin
        mod_vol_we = 4'h0;
        mod_per_we = 4'h0;
        mod_word = 64'h0;
        // Channel 3 has no target, so k stops at 2
        for (k = 0; k < 3; k = k + 1) begin
            mod_word[(k+1)*16 +: 16] = ch_word[k*16 +: 16];
            if (ch_tick[k]) begin
                if (audio_attach_control[k] && audio_attach_control[k+4])
                begin
                    mod_vol_we[k+1] = !alt_period[k];
                    mod_per_we[k+1] = alt_period[k];
                end else begin
                    mod_vol_we[k+1] = audio_attach_control[k];
                    mod_per_we[k+1] = audio_attach_control[k+4];
                end
            end
        end
    end

    // -----------------------------------------------------------
    // Channels, one instance each; channel n can modulate channel n+1
    // -----------------------------------------------------------
    genvar g;
    generate
        for (g = 0; g < 4; g = g + 1) begin : gen_ch
            adma_channel u_ch (
                .clock_i(clock_i),
                .nrst_i(nrst_i),
                .run_i(dma_control[`ADMA_DMA_MASTER_BIT]
                       && dma_control[g]),
                .slot_i(slot_m2[g]),
                .location_i(channel_location[g]),
                .length_i(channel_length[g]),
                .per_we_i(sw_per_we[g] || mod_per_we[g]),
                .per_i(mod_per_we[g] ? mod_word[g*16 +: 16]
                       : reg_wdata_i),
                .vol_we_i(sw_vol_we[g] || mod_vol_we[g]),
                .vol_i(mod_vol_we[g]
                       ? mod_word[g*16 +: `ADMA_VOL_MSB + 1]
                       : reg_wdata_i[`ADMA_VOL_MSB:0]),
                .mem_data_i(mem_data_i),
                .fetch_o(ch_fetch[g]),
                .addr_o(ch_addr[g*18 +: 18]),
                .block_start_o(ch_start[g]),
                .tick_o(ch_tick[g]),
                .word_o(ch_word[g*16 +: 16]),
                .period_o(ch_period[g*16 +: 16]),
                .volume_o(ch_volume[g*7 +: 7])
            );
        end
    endgenerate

    // -----------------------------------------------------------
    // Registered outputs
    // -----------------------------------------------------------
    always @(posedge clock_i or negedge nrst_i) begin
        if (!nrst_i) begin
            mem_req_o <= 4'h0;
            mem_addr_o <= 72'h0;
            sample_o <= 32'h0;
            volume_o <= 28'h0;
        end else begin
            mem_req_o <= ch_fetch;
            mem_addr_o <= ch_addr;
            volume_o <= ch_volume;
            for (k = 0; k < 4; k = k + 1) begin
                if (audio_attach_control[k]
                    || audio_attach_control[k+4]) begin
                    sample_o[k*8 +: 8] <= 8'h00;
                end else if (ch_tick[k]) begin
                    // One byte per sample, high byte of the word
                    sample_o[k*8 +: 8] <= ch_word[k*16+8 +: 8];
                end
            end
        end
    end
endmodule
